// ---- rtl/omcs_pkg.sv ----
// Shared constants and types for the operating mode and clock select block.
package omcs_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OMCS_SMC_OFS = 8'h00;
  localparam logic [7:0] OMCS_STAT_OFS = 8'h04;
  localparam logic [7:0] OMCS_MASK_OFS = 8'h08;
  localparam logic [7:0] OMCS_AUX_OFS = 8'h0C;
  localparam logic [7:0] OMCS_MODE_OFS = 8'h10;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int OMCS_CKS_LSB = 5;
  localparam int OMCS_FAST_WAKE_BIT = 4;
  localparam int OMCS_SLOW_RDY_BIT = 3;
  localparam int OMCS_FAST_RDY_BIT = 2;
  localparam int OMCS_IDLE_HALT_BIT = 1;
  localparam int OMCS_HL_SEL_BIT = 0;
  localparam logic [7:0] OMCS_SMC_RESET = 8'h03;
  localparam logic [7:0] OMCS_SMC_WMASK = 8'hF3;
  localparam int OMCS_AUX_KEEP_BIT = 0;
  localparam int OMCS_AUX_WDT_BIT = 1;
  localparam logic [1:0] OMCS_AUX_RESET = 2'h0;
  localparam logic [2:0] OMCS_CKS_SLOW_MAX = 3'h1;

  // ----------------------------------------------------------------
  // Event bits of the interrupt status and mask registers
  // ----------------------------------------------------------------
  localparam int OMCS_EV_FAST_RDY = 0;
  localparam int OMCS_EV_SLOW_RDY = 1;
  localparam int OMCS_EV_WAKE = 2;
  localparam int OMCS_EV_HALT = 3;
  localparam int OMCS_EV_W = 4;

  // ----------------------------------------------------------------
  // Oscillator settle counts in oscillator cycles
  // ----------------------------------------------------------------
  localparam int OMCS_FAST_XT_CYCLES = 1024;
  localparam int OMCS_FAST_RC_CYCLES = 16;
  localparam int OMCS_SLOW_CYCLES = 2;

  // ----------------------------------------------------------------
  // Operating states and clock outputs
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OMCS_RUN = 3'h0,
    OMCS_RUN_IDLE = 3'h1,
    OMCS_STOP_IDLE = 3'h3,
    OMCS_LIGHT_SLEEP = 3'h2,
    OMCS_DEEP_SLEEP = 3'h6
  } omcs_mode_type;

  typedef struct packed {
    logic hs_osc_en;
    logic slow_rc_en;
    logic tbc_en;
    logic cpu_run;
    logic sys_tick;
  } omcs_clk_out_type;

endpackage

// ---- rtl/omcs_top.sv ----
// Operating mode and system clock select logic with an Avalon-MM register slave.
// Notes on behaviour
// - Normal mode: high-speed clock divided 1 to 64.
// - Slow mode runs from slow RC, fast off.
// - Halt, idle off, watchdog off: deep sleep.
// - Halt, idle off, watchdog on: light sleep.
// - Halt, idle on, keep off: clock-stopped idle.
// - Halt, idle on, keep on: clock-running idle.
// - Select codes: slow RC or fast/64 to /2.
// - High/low select set forces undivided fast clock.
// - Switching to slow RC turns fast oscillator off.
// - Fast wake-up uses slow clock, crystal only.
// - Slow ready flag: low in deep sleep, 2 cycles.
// - Fast ready flag: 1024 crystal or 16 RC cycles.
// - Idle bit picks idle or sleep on halt.
// - After fast wake switch to crystal at 1024.
`timescale 1ns/1ps
`default_nettype none
module omcs_top
  import omcs_pkg::*;
#(
  parameter int FAST_XT_N = OMCS_FAST_XT_CYCLES,
  parameter int FAST_RC_N = OMCS_FAST_RC_CYCLES,
  parameter int SLOW_N = OMCS_SLOW_CYCLES
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic halt_i,
  input wire logic wake_i,
  input wire logic hs_is_crystal_i,
  input wire logic hs_tick_i,
  input wire logic slow_tick_i,
  output omcs_clk_out_type clk_out_o,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // Mask of divider bits that must all be one for a divided tick.
  // A wider mask means a longer period: six ones divide by 64.
  // With the high/low select set the mask is empty, so every tick passes.
  function automatic logic [5:0] div_mask(input logic [2:0] cks, input logic hl);
    logic [5:0] m;
    m = 6'h00;
    if (!hl) begin
      case (cks)
        3'h2: m = 6'h3F;
        3'h3: m = 6'h1F;
        3'h4: m = 6'h0F;
        3'h5: m = 6'h07;
        3'h6: m = 6'h03;
        3'h7: m = 6'h01;
        default: m = 6'h00;
      endcase
    end
    return m;
  endfunction

  // True when the fields pick the slow RC as system clock.
  // The two lowest select codes both mean the slow RC.
  function automatic logic pick_slow(input logic [2:0] cks, input logic hl);
    return !hl && (cks <= OMCS_CKS_SLOW_MAX);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // Every stored bit below holds still while the clock enable is low.
  logic [7:0] smc_q;
  logic [1:0] aux_q;
  logic [OMCS_EV_W-1:0] stat_q;
  logic [OMCS_EV_W-1:0] mask_q;
  omcs_mode_type mode_q;
  logic fast_rdy_q;
  logic slow_rdy_q;
  logic [10:0] hs_cnt_q;
  logic [1:0] lo_cnt_q;
  logic [5:0] div_q;
  logic act_slow_q;
  logic [5:0] act_mask_q;
  logic fast_wake_q;
  logic wait_q;
  logic [31:0] rdata_q;
  omcs_clk_out_type out_q;
  logic irq_q;

  logic sel_slow;
  logic want_slow;
  logic [5:0] want_mask;
  logic hs_on;
  logic lo_on;
  logic cur_tick;
  logic src_alive;
  logic acc;
  logic wr;
  logic fast_rdy_set;
  logic slow_rdy_set;
  logic halt_go;
  logic wake_go;
  logic [10:0] fast_rdy_target;
  logic [OMCS_EV_W-1:0] ev;
  logic [OMCS_EV_W-1:0] clr;

  // Selection requested by software, with fast wake-up overriding it.
  // The override only borrows the slow path; the fast oscillator stays on.
  assign sel_slow = pick_slow(smc_q[OMCS_CKS_LSB +: 3], smc_q[OMCS_HL_SEL_BIT]);
  assign want_slow = sel_slow || fast_wake_q;
  assign want_mask = div_mask(smc_q[OMCS_CKS_LSB +: 3], smc_q[OMCS_HL_SEL_BIT]);

  // Oscillator enables per mode; fast one drops once slow RC is picked.
  // The slow RC runs everywhere except deep sleep, as the watchdog needs it.
  always_comb begin
    hs_on = 1'b0;
    lo_on = 1'b1;
    case (mode_q)
      OMCS_RUN: hs_on = !sel_slow;
      OMCS_RUN_IDLE: hs_on = !sel_slow;
      OMCS_STOP_IDLE: hs_on = 1'b0;
      OMCS_LIGHT_SLEEP: hs_on = 1'b0;
      OMCS_DEEP_SLEEP: lo_on = 1'b0;
      default: hs_on = 1'b0;
    endcase
  end

  // Tick of the active path and whether that path is running.
  assign cur_tick = act_slow_q ? slow_tick_i : (hs_tick_i && ((div_q & act_mask_q) == act_mask_q));
  assign src_alive = act_slow_q ? slow_rdy_q : fast_rdy_q;

  // Bus handshake and event decode.
  // An access is taken in the one cycle in which waitrequest is low.
  // Halt is refused outside run and wake is refused in run.
  assign acc = (avs_read_i || avs_write_i) && !wait_q;
  assign wr = acc && avs_write_i && avs_byteenable_i[0];
  assign fast_rdy_target = hs_is_crystal_i ? 11'(FAST_XT_N - 1) : 11'(FAST_RC_N - 1);
  assign fast_rdy_set = hs_on && !fast_rdy_q && hs_tick_i && (hs_cnt_q == fast_rdy_target);
  assign slow_rdy_set = lo_on && !slow_rdy_q && slow_tick_i && (lo_cnt_q == 2'(SLOW_N - 1));
  assign halt_go = (mode_q == OMCS_RUN) && halt_i;
  assign wake_go = (mode_q != OMCS_RUN) && wake_i;
  assign ev = {halt_go, wake_go, slow_rdy_set, fast_rdy_set};
  assign clr = (wr && avs_address_i == OMCS_STAT_OFS) ? avs_writedata_i[OMCS_EV_W-1:0] : '0;

  // ----------------------------------------------------------------
  // Mode sequencing
  // ----------------------------------------------------------------
  // Halt picks idle or sleep from the control bits; wake returns to run.
  // Halt and wake in one cycle cannot clash, as halt is valid in run only and wake outside run only.
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mode_q <= OMCS_RUN;
    end else if (clk_en_i) begin
      if (halt_go) begin
        if (smc_q[OMCS_IDLE_HALT_BIT]) begin
          mode_q <= aux_q[OMCS_AUX_KEEP_BIT] ? OMCS_RUN_IDLE : OMCS_STOP_IDLE;
        end else begin
          mode_q <= aux_q[OMCS_AUX_WDT_BIT] ? OMCS_LIGHT_SLEEP : OMCS_DEEP_SLEEP;
        end
      end else if (wake_go) begin
        mode_q <= OMCS_RUN;
      end
    end
  end

  // Fast wake-up: only from modes where the slow RC kept running.
  // It ends once the fast oscillator is ready or software picks slow RC.
  // A fast RC settles quickly enough that no substitute clock is used.
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fast_wake_q <= 1'b0;
    end else if (clk_en_i) begin
      if (wake_go && (mode_q == OMCS_LIGHT_SLEEP || mode_q == OMCS_STOP_IDLE)) begin
        fast_wake_q <= smc_q[OMCS_FAST_WAKE_BIT] && hs_is_crystal_i && !sel_slow;
      end else if (fast_rdy_q || sel_slow) begin
        fast_wake_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Oscillator ready flags
  // ----------------------------------------------------------------
  // Fast ready counts oscillator cycles and clears while it is stopped.
  // The count restarts from zero on every restart of the oscillator.
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fast_rdy_q <= 1'b0;
      hs_cnt_q <= 11'h000;
    end else if (clk_en_i) begin
      if (!hs_on) begin
        fast_rdy_q <= 1'b0;
        hs_cnt_q <= 11'h000;
      end else if (fast_rdy_set) begin
        fast_rdy_q <= 1'b1;
      end else if (hs_tick_i && !fast_rdy_q) begin
        hs_cnt_q <= hs_cnt_q + 11'h001;
      end
    end
  end

  // Slow ready counts slow RC cycles and clears in deep sleep.
  // The slow count is the longer end of the allowed settle range.
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      slow_rdy_q <= 1'b0;
      lo_cnt_q <= 2'h0;
    end else if (clk_en_i) begin
      if (!lo_on) begin
        slow_rdy_q <= 1'b0;
        lo_cnt_q <= 2'h0;
      end else if (slow_rdy_set) begin
        slow_rdy_q <= 1'b1;
      end else if (slow_tick_i && !slow_rdy_q) begin
        lo_cnt_q <= lo_cnt_q + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Divider and glitch-free source switch
  // ----------------------------------------------------------------
  // Free divider of the fast oscillator ticks.
  // It is cleared while the oscillator is off so a restart begins in phase.
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      div_q <= 6'h00;
    end else if (clk_en_i) begin
      if (!hs_on) begin
        div_q <= 6'h00;
      end else if (hs_tick_i) begin
        div_q <= div_q + 6'h01;
      end
    end
  end

  // The active path only changes right after it ticked or while dead.
  // Switching at that point keeps every system clock pulse whole.
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      act_slow_q <= 1'b0;
      act_mask_q <= 6'h00;
    end else if (clk_en_i) begin
      if (cur_tick || !src_alive) begin
        act_slow_q <= want_slow;
        act_mask_q <= want_mask;
      end
    end
  end

  // Registered clock outputs, system tick only while the clock runs.
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      out_q <= '0;
    end else if (clk_en_i) begin
      out_q.hs_osc_en <= hs_on;
      out_q.slow_rc_en <= lo_on;
      out_q.tbc_en <= (mode_q == OMCS_RUN) || (mode_q == OMCS_RUN_IDLE) || (mode_q == OMCS_STOP_IDLE);
      out_q.cpu_run <= (mode_q == OMCS_RUN) && src_alive;
      out_q.sys_tick <= ((mode_q == OMCS_RUN) || (mode_q == OMCS_RUN_IDLE)) && src_alive && cur_tick;
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // Control registers; ready flags are not writable.
  // Writes need byte lane zero; the other lanes carry nothing.
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      smc_q <= OMCS_SMC_RESET;
      aux_q <= OMCS_AUX_RESET;
      mask_q <= '0;
    end else if (clk_en_i) begin
      if (wr && avs_address_i == OMCS_SMC_OFS) begin
        smc_q <= avs_writedata_i[7:0] & OMCS_SMC_WMASK;
      end
      if (wr && avs_address_i == OMCS_AUX_OFS) begin
        aux_q <= avs_writedata_i[1:0];
      end
      if (wr && avs_address_i == OMCS_MASK_OFS) begin
        mask_q <= avs_writedata_i[OMCS_EV_W-1:0];
      end
    end
  end

  // Sticky event bits, a new event beats a clear in the same cycle.
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stat_q <= '0;
      irq_q <= 1'b0;
    end else if (clk_en_i) begin
      stat_q <= (stat_q & ~clr) | ev;
      irq_q <= |(((stat_q & ~clr) | ev) & mask_q);
    end
  end

  // Wait one cycle, then present read data for one cycle.
  // Read data drop back to zero whenever waitrequest is high.
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else if (clk_en_i) begin
      wait_q <= !(wait_q && (avs_read_i || avs_write_i));
      rdata_q <= 32'h0000_0000;
      if (wait_q && avs_read_i) begin
        case (avs_address_i)
          OMCS_SMC_OFS: rdata_q <= {24'h00_0000, smc_q[7:4], slow_rdy_q, fast_rdy_q, smc_q[1:0]};
          OMCS_STAT_OFS: rdata_q <= {28'h000_0000, stat_q};
          OMCS_MASK_OFS: rdata_q <= {28'h000_0000, mask_q};
          OMCS_AUX_OFS: rdata_q <= {30'h0000_0000, aux_q};
          OMCS_MODE_OFS: rdata_q <= {27'h000_0000, fast_wake_q, act_slow_q, mode_q};
          default: rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Every output is a plain copy of a flip-flop.
  assign avs_waitrequest_o = wait_q;
  assign avs_readdata_o = rdata_q;
  assign clk_out_o = out_q;
  assign irq_o = irq_q;

endmodule // omcs_top
`default_nettype wire

// ---- verification/omcs_properties.sv ----
// Port-level checker for the operating mode and clock select block.
`timescale 1ns/1ps
`default_nettype none
module omcs_properties
  import omcs_pkg::*;
#(parameter int FAST_XT_N = OMCS_FAST_XT_CYCLES, parameter int FAST_RC_N = OMCS_FAST_RC_CYCLES,
  parameter int SLOW_N = OMCS_SLOW_CYCLES) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic halt_i,
  input wire logic wake_i,
  input wire logic hs_is_crystal_i,
  input wire logic hs_tick_i,
  input wire logic slow_tick_i,
  input wire omcs_clk_out_type clk_out_o,
  input wire logic irq_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  // ------------------------------------------------------------
  // Sequences for a taken halt and a slow-only select write.
  // ------------------------------------------------------------
  sequence halt_taken;
    clk_out_o.cpu_run && halt_i && clk_en_i ##1 clk_en_i;
  endsequence
  sequence slow_written;
    avs_write_i && !avs_waitrequest_o && clk_en_i && avs_address_i == OMCS_SMC_OFS && avs_byteenable_i[0]
      && avs_writedata_i[7:6] == 2'h0 && !avs_writedata_i[0];
  endsequence
  // Bus answers after exactly one wait cycle, for one cycle only.
  bus_wait_once_a:
    assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o && clk_en_i |=> !avs_waitrequest_o)
      else $error("bus request not answered after one wait cycle");
  wait_pulse_a:
    assert property (!avs_waitrequest_o && clk_en_i |=> avs_waitrequest_o) else $error("wait low too long");
  rdata_idle_a:
    assert property (avs_waitrequest_o |-> avs_readdata_o == 32'h0000_0000) else $error("read data not idle");
  halt_stops_cpu_a:
    assert property (halt_taken |=> !clk_out_o.cpu_run) else $error("cpu still running after halt");
  slow_hs_off_a:
    assert property (slow_written |-> ##[2:400] !clk_out_o.hs_osc_en) else $error("fast osc left on");
  sleep_gate_a:
    assert property (!clk_out_o.tbc_en |-> !clk_out_o.hs_osc_en && !clk_out_o.cpu_run && !clk_out_o.sys_tick)
      else $error("clock running with time base stopped");
  deep_sleep_a:
    assert property (!clk_out_o.slow_rc_en |-> !clk_out_o.tbc_en) else $error("time base on with slow rc off");
  run_clocks_a:
    assert property (clk_out_o.cpu_run |-> clk_out_o.slow_rc_en && clk_out_o.tbc_en)
      else $error("slow rc or time base off while running");
endmodule // omcs_properties
bind omcs_top omcs_properties #(.FAST_XT_N(FAST_XT_N), .FAST_RC_N(FAST_RC_N), .SLOW_N(SLOW_N)) chk_u (
  .clock_i(clock_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .halt_i(halt_i), .wake_i(wake_i), .hs_is_crystal_i(hs_is_crystal_i), .hs_tick_i(hs_tick_i),
  .slow_tick_i(slow_tick_i), .clk_out_o(clk_out_o), .irq_o(irq_o));
`default_nettype wire

// ---- verification/omcs_top_tb.sv ----
// Self-checking testbench for the operating mode and clock select block.
`timescale 1ns/1ps
`default_nettype none
module omcs_top_tb
  import omcs_pkg::*;
;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic clk_en_i = 1'b1;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0000_0000;
  logic [3:0] avs_byteenable_i = 4'h1;
  logic halt_i = 1'b0;
  logic wake_i = 1'b0;
  logic hs_is_crystal_i = 1'b1;
  logic hs_tick_i = 1'b0;
  logic slow_tick_i = 1'b0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  omcs_clk_out_type clk_out_o;
  logic irq_o;
  logic [2:0] tick_cnt_q = 3'h0;
  logic [31:0] rd;
  logic [9:0] tbl [4] = '{10'h006, 10'h0A2, 10'h233, 10'h371};
  int error_cnt = 0;
  int total_checks = 0;
  int per;
  omcs_top #(.FAST_XT_N(8), .FAST_RC_N(4), .SLOW_N(2)) dut_u (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .halt_i(halt_i), .wake_i(wake_i), .hs_is_crystal_i(hs_is_crystal_i),
    .hs_tick_i(hs_tick_i), .slow_tick_i(slow_tick_i), .clk_out_o(clk_out_o), .irq_o(irq_o));
  // Clock generator; fast oscillator ticks every 2 cycles, slow RC every 8.
  initial begin
    forever #2 clock_i = ~clock_i;
  end
  always_ff @(posedge clock_i) begin
    tick_cnt_q <= tick_cnt_q + 3'h1;
    hs_tick_i <= tick_cnt_q[0];
    slow_tick_i <= (tick_cnt_q == 3'h7);
  end
  // One bus access held until waitrequest is seen low.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    @(posedge clock_i);
    while (avs_waitrequest_o !== 1'b0 && n < 50) begin
      @(posedge clock_i);
      n++;
    end
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Pulses halt or wake for one cycle.
  task automatic pulse(input logic w);
    if (w) wake_i <= 1'b1;
    else halt_i <= 1'b1;
    @(posedge clock_i);
    wake_i <= 1'b0;
    halt_i <= 1'b0;
    repeat (3) @(posedge clock_i);
  endtask
  task automatic wait_cpu();
    int n;
    n = 0;
    while (clk_out_o.cpu_run !== 1'b1 && n < 600) begin
      @(posedge clock_i);
      n++;
    end
    chk({31'h0, clk_out_o.cpu_run}, 32'h0000_0001);
  endtask
  // Cycles between system clock ticks, taken on the second full interval.
  task automatic measure();
    int n;
    repeat (40) @(posedge clock_i);
    for (int k = 0; k < 3; k++) begin
      n = 0;
      @(posedge clock_i);
      while (clk_out_o.sys_tick !== 1'b1 && n < 400) begin
        @(posedge clock_i);
        n++;
      end
      per = n + 1;
    end
  endtask
  task automatic end_of_test();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Watchdog sized well beyond the expected run length.
  initial begin
    #80000;
    error_cnt++;
    end_of_test();
  end
  // ------------------------------------------------------------
  // Main test sequence.
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    repeat (60) @(posedge clock_i);
    bus(1'b0, OMCS_SMC_OFS, 32'h0000_0000);
    chk(rd, 32'h0000_000F);
    bus(1'b0, OMCS_STAT_OFS, 32'h0000_0000);
    chk(rd, 32'h0000_0003);
    bus(1'b0, OMCS_MODE_OFS, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    bus(1'b1, 8'h20, 32'h0000_00FF);
    bus(1'b0, 8'h20, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    // Every select code, then the undivided fast clock.
    for (int c = 0; c < 9; c++) begin
      bus(1'b1, OMCS_SMC_OFS, (c < 8) ? {24'h0, 3'(c), 5'h00} : 32'h0000_0001);
      measure();
      chk(32'(per), (c < 2) ? 32'h0000_0008 : (c == 8) ? 32'h0000_0002 : 32'(1 << (9 - c)));
      if (c == 0) begin
        bus(1'b0, OMCS_SMC_OFS, 32'h0000_0000);
        chk(rd, 32'h0000_0008);
        bus(1'b0, OMCS_MODE_OFS, 32'h0000_0000);
        chk(rd, 32'h0000_0008);
      end
    end
    // Each halt mode from the fast clock.
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, OMCS_SMC_OFS, {30'h0, tbl[i][9], 1'b1});
      bus(1'b1, OMCS_AUX_OFS, {30'h0, tbl[i][7], tbl[i][8]});
      pulse(1'b0);
      chk({28'h0, clk_out_o[4:1]}, {28'h0, tbl[i][6:3]});
      bus(1'b0, OMCS_MODE_OFS, 32'h0000_0000);
      chk(rd, {29'h0, tbl[i][2:0]});
      pulse(1'b1);
      wait_cpu();
    end
    // Interrupt masked, unmasked, then cleared.
    chk({31'h0, irq_o}, 32'h0000_0000);
    bus(1'b1, OMCS_MASK_OFS, 32'h0000_0004);
    repeat (3) @(posedge clock_i);
    chk({31'h0, irq_o}, 32'h0000_0001);
    bus(1'b1, OMCS_STAT_OFS, 32'h0000_001F);
    repeat (3) @(posedge clock_i);
    chk({31'h0, irq_o}, 32'h0000_0000);
    // Fast wake-up from light sleep, crystal then fast RC.
    for (int j = 0; j < 2; j++) begin
      hs_is_crystal_i <= (j == 0);
      bus(1'b1, OMCS_SMC_OFS, 32'h0000_0011);
      bus(1'b1, OMCS_AUX_OFS, 32'h0000_0002);
      pulse(1'b0);
      wake_i <= 1'b1;
      @(posedge clock_i);
      wake_i <= 1'b0;
      bus(1'b0, OMCS_MODE_OFS, 32'h0000_0000);
      chk({31'h0, rd[4]}, (j == 0) ? 32'h0000_0001 : 32'h0000_0000);
      wait_cpu();
      repeat (40) @(posedge clock_i);
      bus(1'b0, OMCS_MODE_OFS, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
    end
    end_of_test();
  end
endmodule // omcs_top_tb
`default_nettype wire
